// *** design/gdfm_fault_manager.sv ***
// Fault latching, safe-state selection, alarms and supply gating
`timescale 1ns/1ps
`include "gdfm_map.svh"

// Function
// - Overtemp: latch, safe state, fault alarm
// - Gate monitor: latch, high impedance, no warning
// - Shoot-through: latch, selectable low, fault alarm
// - Primary clock loss: low, alarm, serial off
// - Secondary clock: latch, always low, serial on
// - Regulator faults: per-side bit and safe state
// - Primary regulator overvoltage: secondary link, serial off
// - Secondary regulator overvoltage: primary link fault
// - Serial errors: shared bit, warning only
// - Config checksum: per-side bit, safe state
// - Trim checksum: both alarms, primary always low
// - Self-test failures: low, both alarms
// - Link faults: primary alarm masked by default
// - Reference voltage fault: converter bit, alarm masked by default
// - Switch overvoltage: latch, soft turn-off only
// - Regulator overcurrent: own bit, alarm only
// - Reference overcurrent: converter bit, alarm only
// - Power up needs valid supplies
// - High impedance until supplies valid
// - Then enable command plus faults decide
// - No serial while primary undervoltage
// - Supply check disables and thresholds
// - Mask hides alarm, status still reports
// - Safe state: low, high, high impedance or none
// - Clear needs condition gone plus command
// - Alarm holds while condition persists
module gdfm_fault_manager (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`GDFM_AW-1:0]      paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Detector inputs, asynchronous
    input  wire logic [`GDFM_NSRC-1:0]    fault_cond,
    input  wire logic [1:0]               regulator_ov,
    input  wire gdfm_pkg::gdfm_supply_type supply,
    input  wire logic                     osc_mon_clk,
    // Driver and serial port control
    output gdfm_pkg::gdfm_drive_type      drive_state,
    output logic                          serial_enable,
    output logic                          power_good,
    // Alarm pins
    output logic                          fault_alarm_n,
    output logic                          warning_alarm_n,
    // Supply monitor setup
    output gdfm_pkg::gdfm_check_type      checks,
    output gdfm_pkg::gdfm_thresh_type     thresholds
);

    localparam int N      = `GDFM_NSRC;
    localparam int SW     = N + 2 + 7 + 1;
    localparam int CM_CYC = (`GDFM_CLKMON_NS + `GDFM_PCLK_NS - 1) / `GDFM_PCLK_NS;
    localparam int CM_W   = $clog2(CM_CYC + 1);

    // Tables as typed constants so each source can pick its own bit
    localparam logic [N-1:0] SEL_TAB    = `GDFM_SEL_TAB;
    localparam logic [N-1:0] FIXLOW_TAB = `GDFM_FIXLOW_TAB;
    localparam logic [N-1:0] STO_TAB    = `GDFM_STO_TAB;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [SW-1:0]             meta_q;
    logic [SW-1:0]             sync_q;
    logic [N-1:0]              cond_s;
    logic [1:0]                regov_s;
    gdfm_pkg::gdfm_supply_type supply_s;
    logic                      mclk_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {osc_mon_clk, supply, regulator_ov, fault_cond};
            sync_q <= meta_q;
        end
    end

    assign cond_s   = sync_q[N-1:0];
    assign regov_s  = sync_q[N+1:N];
    assign supply_s = sync_q[N+8:N+2];
    assign mclk_s   = sync_q[SW-1];

    ////////////////////////////////////////////////////////////////////////////
    // Primary oscillator monitor

    logic            mclk_prev_q;
    logic [CM_W-1:0] cm_cnt_q;
    logic            clk_stuck;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_prev_q <= 1'b0;
        end else begin
            mclk_prev_q <= mclk_s;
        end
    end

    // Counter saturates so a dead clock stays flagged until edges return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cm_cnt_q <= '0;
        end else if (mclk_s != mclk_prev_q) begin
            cm_cnt_q <= '0;
        end else if (cm_cnt_q != CM_W'(CM_CYC)) begin
            cm_cnt_q <= cm_cnt_q + 1'b1;
        end
    end

    assign clk_stuck = (cm_cnt_q == CM_W'(CM_CYC));

    ////////////////////////////////////////////////////////////////////////////
    // Registers and APB access

    logic [N-1:0]              status_q;
    logic [N-1:0]              mask_q;
    logic [31:0]               safe_q;
    logic                      drive_en_q;
    logic [19:0]               supply_q;
    logic [31:0]               prdata_q;
    logic                      wr;
    logic                      hit;
    logic                      clr;
    logic [31:0]               rdata_d;
    gdfm_pkg::gdfm_power_type  pwr_q;
    gdfm_pkg::gdfm_drive_type  drive_q;
    logic                      serial_q;
    logic                      fault_n_q;
    logic                      warn_n_q;

    assign wr  = psel && penable && pwrite;
    assign hit = (paddr == `GDFM_STATUS_OFS) || (paddr == `GDFM_MASK_OFS)
              || (paddr == `GDFM_SAFE_OFS) || (paddr == `GDFM_CTRL_OFS)
              || (paddr == `GDFM_SUPPLY_OFS) || (paddr == `GDFM_STATE_OFS);
    assign clr = wr && (paddr == `GDFM_CTRL_OFS) && pwdata[`GDFM_CTRL_CLR];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `GDFM_MASK_RST;
        end else if (wr && paddr == `GDFM_MASK_OFS) begin
            mask_q <= pwdata[N-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safe_q <= `GDFM_SAFE_RST;
        end else if (wr && paddr == `GDFM_SAFE_OFS) begin
            safe_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_en_q <= 1'b0;
        end else if (wr && paddr == `GDFM_CTRL_OFS) begin
            drive_en_q <= pwdata[`GDFM_CTRL_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_q <= `GDFM_SUPPLY_RST;
        end else if (wr && paddr == `GDFM_SUPPLY_OFS) begin
            supply_q <= pwdata[19:0];
        end
    end

    assign checks     = supply_q[4:0];
    assign thresholds = supply_q[`GDFM_SUP_TH +: 12];

    // Converter bit shows both reference causes
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (paddr)
            `GDFM_STATUS_OFS: begin
                rdata_d[N-2:0]      = status_q[N-2:0];
                rdata_d[`GDFM_CONV] = status_q[`GDFM_CONV] | status_q[`GDFM_VREFOC];
            end
            `GDFM_MASK_OFS:   rdata_d[N-1:0] = mask_q;
            `GDFM_SAFE_OFS:   rdata_d = safe_q;
            `GDFM_CTRL_OFS:   rdata_d[`GDFM_CTRL_EN] = drive_en_q;
            `GDFM_SUPPLY_OFS: rdata_d[19:0] = supply_q;
            `GDFM_STATE_OFS:  rdata_d[4:0] = {drive_q, serial_q, pwr_q == gdfm_pkg::PWR_RUN};
            default:          rdata_d = 32'h00000000;
        endcase
    end

    // Read data captured in the setup cycle, so zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault conditions and sticky status

    logic [N-1:0] cond;

    always_comb begin
        cond                = cond_s;
        cond[`GDFM_PCLKMON] = cond_s[`GDFM_PCLKMON] | clk_stuck;
        // Regulator overvoltage has no bit of its own, only the link fault
        cond[`GDFM_SLINK]   = cond_s[`GDFM_SLINK] | regov_s[0];
        cond[`GDFM_PLINK]   = cond_s[`GDFM_PLINK] | regov_s[1];
    end

    // A live condition wins over the clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= cond | (clr ? '0 : status_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-source safe-state action

    logic [N-1:0] act_low;
    logic [N-1:0] act_high;
    logic [N-1:0] act_hiz;
    logic [N-1:0] act_sto;

    for (genvar i = 0; i < N; i++) begin : g_src
        logic [1:0] code;
        logic [1:0] fixed;
        assign fixed = FIXLOW_TAB[i] ? `GDFM_SAFE_LOW : `GDFM_SAFE_NONE;
        if (i < 16) begin : g_sel
            assign code = SEL_TAB[i] ? safe_q[2*i +: 2] : fixed;
        end else begin : g_fix
            assign code = fixed;
        end
        assign act_low[i]  = status_q[i] && (code == `GDFM_SAFE_LOW);
        assign act_high[i] = status_q[i] && (code == `GDFM_SAFE_HIGH);
        assign act_hiz[i]  = status_q[i] && (code == `GDFM_SAFE_HIZ);
        assign act_sto[i]  = status_q[i] && STO_TAB[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply checks and power-up

    logic pri_bad;
    logic pri_uv_eff;
    logic sec_uv_eff;
    logic supply_trip;
    logic up_ok;

    assign pri_uv_eff  = supply_s.pri_uv && !checks.pri_uv_dis;
    assign pri_bad     = pri_uv_eff || (supply_s.pri_ov && !checks.pri_ov_dis);
    assign sec_uv_eff  = supply_s.sec_uv && !checks.sec_uv_dis;
    assign supply_trip = (supply_s.sec_ov && !checks.sec_ov_dis)
                      || (checks.neg_en && (supply_s.neg_uv || supply_s.neg_ov));
    assign up_ok       = !pri_bad && !sec_uv_eff && supply_s.reg_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= gdfm_pkg::PWR_WAIT;
        end else begin
            unique case (pwr_q)
                gdfm_pkg::PWR_WAIT: if (up_ok) pwr_q <= gdfm_pkg::PWR_RUN;
                gdfm_pkg::PWR_RUN:  if (!up_ok) pwr_q <= gdfm_pkg::PWR_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Driver state; pull-low outranks every other safe state

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= gdfm_pkg::DRV_HIZ;
        end else if (pwr_q != gdfm_pkg::PWR_RUN) begin
            drive_q <= gdfm_pkg::DRV_HIZ;
        end else if (|act_low || supply_trip) begin
            drive_q <= gdfm_pkg::DRV_LOW;
        end else if (|act_sto) begin
            drive_q <= gdfm_pkg::DRV_STO;
        end else if (|act_hiz) begin
            drive_q <= gdfm_pkg::DRV_HIZ;
        end else if (|act_high) begin
            drive_q <= gdfm_pkg::DRV_HIGH;
        end else begin
            drive_q <= drive_en_q ? gdfm_pkg::DRV_PWM : gdfm_pkg::DRV_LOW;
        end
    end

    assign drive_state = drive_q;
    assign power_good  = (pwr_q == gdfm_pkg::PWR_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Serial port enable; not latched, returns with the clock

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_q <= 1'b0;
        end else begin
            serial_q <= !pri_uv_eff && !clk_stuck && !regov_s[0];
        end
    end

    assign serial_enable = serial_q;

    ////////////////////////////////////////////////////////////////////////////
    // Alarm pins

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_n_q <= 1'b1;
            warn_n_q  <= 1'b1;
        end else begin
            fault_n_q <= ~|(status_q & ~mask_q & `GDFM_FLT_ROUTE);
            warn_n_q  <= ~|(status_q & ~mask_q & `GDFM_WRN_ROUTE);
        end
    end

    assign fault_alarm_n   = fault_n_q;
    assign warning_alarm_n = warn_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ot_rise;
        $rose(cond[`GDFM_OVERTEMP]) && !mask_q[`GDFM_OVERTEMP];
    endsequence

    sequence s_ot_clear;
        clr && !cond[`GDFM_OVERTEMP];
    endsequence

    ot_alarm_a: assert property (s_ot_rise |=> status_q[`GDFM_OVERTEMP] ##1 !fault_alarm_n)
        else $error("overtemp did not raise fault alarm");

    ot_low_a: assert property ((pwr_q == gdfm_pkg::PWR_RUN) && status_q[`GDFM_OVERTEMP]
        && safe_q[1:0] == `GDFM_SAFE_LOW |=> drive_state == gdfm_pkg::DRV_LOW)
        else $error("overtemp did not pull output low");

    gm_hiz_a: assert property ((pwr_q == gdfm_pkg::PWR_RUN) && status_q == 22'h000002
        && safe_q[3:2] == `GDFM_SAFE_HIZ && !supply_trip
        |=> drive_state == gdfm_pkg::DRV_HIZ && warning_alarm_n)
        else $error("gate monitor fault not high impedance");

    clk_serial_a: assert property (clk_stuck |=> !serial_enable)
        else $error("serial port alive on clock loss");

    serial_warn_a: assert property (status_q == 22'h000080 && !mask_q[`GDFM_SERIAL]
        |=> !warning_alarm_n && fault_alarm_n)
        else $error("serial fault alarm routing wrong");

    trim_alarms_a: assert property (status_q[`GDFM_PTRIM] && !mask_q[`GDFM_PTRIM]
        |=> !fault_alarm_n && !warning_alarm_n)
        else $error("trim fault missed an alarm");

    uv_serial_a: assert property (supply_s.pri_uv && !checks.pri_uv_dis |=> !serial_enable)
        else $error("serial enabled during undervoltage");

    hiz_power_a: assert property (pwr_q == gdfm_pkg::PWR_WAIT |=> drive_state == gdfm_pkg::DRV_HIZ)
        else $error("output driven before supplies valid");

    clear_gone_a: assert property (s_ot_clear |=> !status_q[`GDFM_OVERTEMP])
        else $error("clear did not drop status");

    sticky_hold_a: assert property (status_q[`GDFM_OVERTEMP] && !clr
        |=> status_q[`GDFM_OVERTEMP] [*1])
        else $error("status dropped without clear");

    mask_quiet_a: assert property ((status_q & ~mask_q & `GDFM_FLT_ROUTE) == '0 |=> fault_alarm_n)
        else $error("masked fault reached alarm");

    persist_alarm_a: assert property (cond[`GDFM_OVERTEMP] && !mask_q[`GDFM_OVERTEMP]
        |=> ##1 !fault_alarm_n)
        else $error("alarm released while condition persists");

endmodule

// *** design/gdfm_map.svh ***
// Offsets, field positions, reset values and timings in ns of the fault manager
`ifndef GDFM_MAP_SVH
`define GDFM_MAP_SVH
`define GDFM_NSRC 22
`define GDFM_AW 12
`define GDFM_STATUS_OFS 12'h000
`define GDFM_MASK_OFS 12'h004
`define GDFM_SAFE_OFS 12'h008
`define GDFM_CTRL_OFS 12'h00C
`define GDFM_SUPPLY_OFS 12'h010
`define GDFM_STATE_OFS 12'h014
`define GDFM_MASK_RST 22'h014000
`define GDFM_SAFE_RST 32'h5555155D
`define GDFM_SUPPLY_RST 20'h00000
`define GDFM_SEL_TAB 22'h00CBEF
`define GDFM_FIXLOW_TAB 22'h043410
`define GDFM_STO_TAB 22'h020000
`define GDFM_FLT_ROUTE 22'h3DFF7F
`define GDFM_WRN_ROUTE 22'h003C80
`define GDFM_SAFE_NONE 2'h0
`define GDFM_SAFE_LOW 2'h1
`define GDFM_SAFE_HIGH 2'h2
`define GDFM_SAFE_HIZ 2'h3
`define GDFM_CTRL_CLR 0
`define GDFM_CTRL_EN 1
`define GDFM_SUP_PUVD 0
`define GDFM_SUP_POVD 1
`define GDFM_SUP_SUVD 2
`define GDFM_SUP_SOVD 3
`define GDFM_SUP_NEN 4
`define GDFM_SUP_TH 8
`define GDFM_OVERTEMP 0
`define GDFM_GATEMON 1
`define GDFM_PCLKMON 3
`define GDFM_PREG 5
`define GDFM_SREG 6
`define GDFM_SERIAL 7
`define GDFM_PTRIM 10
`define GDFM_PLINK 14
`define GDFM_SLINK 15
`define GDFM_CONV 16
`define GDFM_VREFOC 21
`define GDFM_PCLK_NS 10
`define GDFM_CLKMON_NS 640
`endif

// *** design/gdfm_pkg.sv ***
// Types shared by the fault manager
package gdfm_pkg;
    typedef enum logic [2:0] {DRV_HIZ, DRV_PWM, DRV_LOW, DRV_HIGH, DRV_STO} gdfm_drive_type;
    typedef enum logic {PWR_WAIT, PWR_RUN} gdfm_power_type;
    typedef struct packed {
        logic pri_uv;
        logic pri_ov;
        logic sec_uv;
        logic sec_ov;
        logic neg_uv;
        logic neg_ov;
        logic reg_ok;
    } gdfm_supply_type;
    typedef struct packed {
        logic       neg_en;
        logic       sec_ov_dis;
        logic       sec_uv_dis;
        logic       pri_ov_dis;
        logic       pri_uv_dis;
    } gdfm_check_type;
    typedef struct packed {
        logic [1:0] neg_ov;
        logic [1:0] neg_uv;
        logic [1:0] sec_ov;
        logic [1:0] sec_uv;
        logic [1:0] pri_ov;
        logic [1:0] pri_uv;
    } gdfm_thresh_type;
endpackage

// *** sim/gdfm_osc_model.sv ***
// Monitored oscillator standing in for the primary clock source
`timescale 1ns/1ps

module gdfm_osc_model #(
    parameter int HALF_NS = 80
) (
    // Control from the bench
    input  wire logic run,
    // Oscillator seen by the block
    output logic      osc_mon_clk
);
    initial begin
        osc_mon_clk = 1'b0;
        forever begin
            #(HALF_NS);
            // A stopped oscillator sticks at its last level
            if (run) begin
                osc_mon_clk = ~osc_mon_clk;
            end
        end
    end
endmodule

// *** sim/gdfm_fault_manager_tb.sv ***
// Self-checking bench for the fault manager over APB
`timescale 1ns/1ps
`include "gdfm_map.svh"

module gdfm_fault_manager_tb;
    logic                      pclk;
    logic                      presetn;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [`GDFM_AW-1:0]       paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [`GDFM_NSRC-1:0]     fault_cond;
    logic [1:0]                regulator_ov;
    gdfm_pkg::gdfm_supply_type supply;
    logic                      osc_run;
    logic                      osc_mon_clk;
    gdfm_pkg::gdfm_drive_type  drive_state;
    logic                      serial_enable;
    logic                      power_good;
    logic                      fault_alarm_n;
    logic                      warning_alarm_n;
    gdfm_pkg::gdfm_check_type  supply_checks;
    gdfm_pkg::gdfm_thresh_type thresholds;
    logic [31:0]               rdata;
    logic                      rerr;
    int                        fail_count;
    int                        checks;

    gdfm_fault_manager i_dut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .fault_cond      (fault_cond),
        .regulator_ov    (regulator_ov),
        .supply          (supply),
        .osc_mon_clk     (osc_mon_clk),
        .drive_state     (drive_state),
        .serial_enable   (serial_enable),
        .power_good      (power_good),
        .fault_alarm_n   (fault_alarm_n),
        .warning_alarm_n (warning_alarm_n),
        .checks          (supply_checks),
        .thresholds      (thresholds)
    );

    gdfm_osc_model i_osc (
        .run         (osc_run),
        .osc_mon_clk (osc_mon_clk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Setup then access; waits on pready, never a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, exp);
    endtask

    // Raise one detector, check reaction, refused and accepted clear
    task automatic inject(input int src, input int sbit, input gdfm_pkg::gdfm_drive_type drv,
                          input logic flt, input logic wrn);
        @(posedge pclk);
        fault_cond[src] <= 1'b1;
        wait_cyc(6);
        check({29'h0, drive_state}, {29'h0, drv});
        check({30'h0, fault_alarm_n, warning_alarm_n}, {30'h0, flt, wrn});
        wr(`GDFM_CTRL_OFS, 32'h3);
        rd(`GDFM_STATUS_OFS, 32'h1 << sbit);
        @(posedge pclk);
        fault_cond[src] <= 1'b0;
        wait_cyc(4);
        wr(`GDFM_CTRL_OFS, 32'h3);
        rd(`GDFM_STATUS_OFS, 32'h0);
        wait_cyc(3);
        check({30'h0, fault_alarm_n, warning_alarm_n}, 32'h3);
        check({29'h0, drive_state}, {29'h0, gdfm_pkg::DRV_PWM});
    endtask

    task automatic regov(input int idx, input int sbit, input logic ser, input logic flt);
        @(posedge pclk);
        regulator_ov[idx] <= 1'b1;
        wait_cyc(6);
        check({30'h0, serial_enable, fault_alarm_n}, {30'h0, ser, flt});
        check({29'h0, drive_state}, {29'h0, gdfm_pkg::DRV_LOW});
        rd(`GDFM_STATUS_OFS, 32'h1 << sbit);
        @(posedge pclk);
        regulator_ov[idx] <= 1'b0;
        wait_cyc(6);
        wr(`GDFM_CTRL_OFS, 32'h3);
        rd(`GDFM_STATUS_OFS, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole run is about a thousand cycles
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial begin
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = '0;
        pwdata       = '0;
        fault_cond   = '0;
        regulator_ov = '0;
        osc_run      = 1'b1;
        supply       = '{pri_ov: 1'b1, reg_ok: 1'b1, default: 1'b0};
        fail_count   = 0;
        checks       = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_cyc(6);
        // Primary overvoltage holds off power-up
        check({28'h0, power_good, drive_state}, {28'h0, 1'b0, gdfm_pkg::DRV_HIZ});
        @(posedge pclk);
        supply.pri_ov <= 1'b0;
        wait_cyc(6);
        check({28'h0, power_good, drive_state}, {28'h0, 1'b1, gdfm_pkg::DRV_LOW});
        rd(`GDFM_MASK_OFS, 32'h0001_4000);
        rd(`GDFM_SAFE_OFS, 32'h5555_155D);
        rd(`GDFM_SUPPLY_OFS, 32'h0);
        apb(1'b0, 12'h018, 32'h0, rdata, rerr);
        check({rerr, rdata[30:0]}, 32'h8000_0000);
        wr(`GDFM_STATUS_OFS, 32'hFFFF_FFFF);
        rd(`GDFM_STATUS_OFS, 32'h0);
        wr(`GDFM_SUPPLY_OFS, 32'h000F_FF1F);
        rd(`GDFM_SUPPLY_OFS, 32'h000F_FF1F);
        check({15'h0, supply_checks, thresholds}, {15'h0, 5'h1F, 12'hFFF});
        wr(`GDFM_SUPPLY_OFS, 32'h0);
        wr(`GDFM_CTRL_OFS, 32'h2);
        rd(`GDFM_CTRL_OFS, 32'h2);
        wait_cyc(2);
        check({29'h0, drive_state}, {29'h0, gdfm_pkg::DRV_PWM});
        rd(`GDFM_STATE_OFS, 32'h7);
        inject(0, 0, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(1, 1, gdfm_pkg::DRV_HIZ, 1'b0, 1'b1);
        inject(2, 2, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(4, 4, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(5, 5, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(6, 6, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(8, 8, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(11, 11, gdfm_pkg::DRV_LOW, 1'b0, 1'b0);
        inject(12, 12, gdfm_pkg::DRV_LOW, 1'b0, 1'b0);
        inject(18, 18, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(20, 20, gdfm_pkg::DRV_PWM, 1'b0, 1'b1);
        inject(7, 7, gdfm_pkg::DRV_PWM, 1'b1, 1'b0);
        inject(9, 9, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(10, 10, gdfm_pkg::DRV_LOW, 1'b0, 1'b0);
        inject(13, 13, gdfm_pkg::DRV_LOW, 1'b0, 1'b0);
        inject(14, 14, gdfm_pkg::DRV_LOW, 1'b1, 1'b1);
        inject(15, 15, gdfm_pkg::DRV_LOW, 1'b0, 1'b1);
        inject(16, 16, gdfm_pkg::DRV_PWM, 1'b1, 1'b1);
        inject(17, 17, gdfm_pkg::DRV_STO, 1'b1, 1'b1);
        inject(19, 19, gdfm_pkg::DRV_PWM, 1'b0, 1'b1);
        inject(21, 16, gdfm_pkg::DRV_PWM, 1'b0, 1'b1);
        // Mask hides the alarm only; safe state high and none
        wr(`GDFM_MASK_OFS, 32'h0001_4001);
        inject(0, 0, gdfm_pkg::DRV_LOW, 1'b1, 1'b1);
        wr(`GDFM_MASK_OFS, 32'h0001_4000);
        wr(`GDFM_SAFE_OFS, 32'h5555_155E);
        inject(0, 0, gdfm_pkg::DRV_HIGH, 1'b0, 1'b1);
        wr(`GDFM_SAFE_OFS, 32'h5555_155C);
        inject(0, 0, gdfm_pkg::DRV_PWM, 1'b0, 1'b1);
        wr(`GDFM_SAFE_OFS, 32'h5555_155D);
        regov(0, 15, 1'b0, 1'b0);
        regov(1, 14, 1'b1, 1'b1);
        // Oscillator stops well past the 64-cycle limit
        @(posedge pclk);
        osc_run <= 1'b0;
        wait_cyc(100);
        check({28'h0, serial_enable, drive_state}, {28'h0, 1'b0, gdfm_pkg::DRV_LOW});
        check({31'h0, fault_alarm_n}, 32'h0);
        rd(`GDFM_STATUS_OFS, 32'h8);
        @(posedge pclk);
        osc_run <= 1'b1;
        wait_cyc(30);
        check({31'h0, serial_enable}, 32'h1);
        wr(`GDFM_CTRL_OFS, 32'h3);
        rd(`GDFM_STATUS_OFS, 32'h0);
        @(posedge pclk);
        supply.pri_uv <= 1'b1;
        wait_cyc(6);
        check({31'h0, serial_enable}, 32'h0);
        @(posedge pclk);
        supply.pri_uv <= 1'b0;
        wait_cyc(6);
        check({31'h0, serial_enable}, 32'h1);
        // Secondary overvoltage pulls low unless its check is disabled
        @(posedge pclk);
        supply.sec_ov <= 1'b1;
        wait_cyc(6);
        check({29'h0, drive_state}, {29'h0, gdfm_pkg::DRV_LOW});
        wr(`GDFM_SUPPLY_OFS, 32'h8);
        wait_cyc(2);
        check({29'h0, drive_state}, {29'h0, gdfm_pkg::DRV_PWM});
        @(posedge pclk);
        supply.sec_ov <= 1'b0;
        wr(`GDFM_SUPPLY_OFS, 32'h0);
        give_verdict();
    end
endmodule
